// *** gcm_misc_ctrl.sv ***
// Global misc control: drive strength, in-band frame status, indicator overrides
// Contract
// - Good frame sets status bit 31
// - Reply sent sets status bit 30
// - All commands executed sets bit 29
// - Tag-matching frame clears reply, execution, error flags
// - Mismatch flag updates only with check enabled; a tag-matching frame clears it even with check off
// - Destination differing from station sets mismatch
// - Format not 0x9800 sets bit 13
// - Code not 0x0001/0x0002 sets bit 12
// - Unknown command code sets bit 11
// - Over 320 bytes sets bit 10, no reply
// - Bits 6:0 give faulty command location
// - Override bit chooses indicator or general output
// - Bit 0 is first port first pin
// - General output pin follows its level bit
// - Override and level bits reset to zero
// - High speed drive bits 6:4, reset 110b
// - Low speed drive bits 2:0, reset 10b
// - Checked mismatching frames are discarded
`timescale 1ns/1ps

module gcm_misc_ctrl (
	input wire logic SYS_CLK_I,
	input wire logic RESET_I,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [11:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	input wire gcm_pkg::gcm_frame_s FRAME_I,
	input wire logic RESP_SENT_I,
	input wire logic EXEC_DONE_I,
	input wire logic [9:0] INDICATOR_STATUS_I,
	output logic [9:0] INDICATOR_PIN_O,
	output logic [2:0] HS_DRIVE_O,
	output logic [2:0] LS_DRIVE_O,
	output logic DISCARD_O,
	output logic NO_REPLY_O,
	output logic IRQ_O
);
	import gcm_pkg::*;

	// Byte-lane merge of a write into a stored word
	function automatic logic [31:0] lane_merge(
		input logic [31:0] old_val,
		input logic [31:0] new_val,
		input logic [3:0] sel
	);
		logic [31:0] res;
		res = old_val;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[b*8 +: 8] = new_val[b*8 +: 8];
			end
		end
		return res;
	endfunction : lane_merge

	// Write strobe decode for one register index
	function automatic logic wr_hit(
		input logic strobe,
		input logic [9:0] idx,
		input logic [9:0] want
	);
		return strobe && (idx == want);
	endfunction : wr_hit

	// Bus decode
	logic [9:0] bus_idx; // Word index of the access
	logic bus_req, bus_wr; // New request and new write, not yet answered
	logic [31:0] rd_word; // Read value of the addressed register
	logic [31:0] wr_merged; // Addressed register with the write's byte lanes applied

	// Software state
	logic dest_check; // Destination check enable
	logic [7:0] drive; // Drive strength register, reserved bits kept
	logic [9:0] override; // Per-pin general output select
	logic [9:0] level; // Per-pin general output level
	logic [47:0] station; // Programmed station address
	logic [7:0] irq_status; // Sticky event bits
	logic [7:0] irq_mask; // Interrupt enables

	// In-band status flags, kept until the next tag-matching frame
	logic st_good, st_resp, st_exec, st_mismatch, st_format, st_code, st_cmd, st_oversize;
	logic [6:0] st_loc; // Faulty command location

	// Frame evaluation
	logic fr_done; // Frame summary strobe
	logic fr_clear; // Frame that restarts the flags
	logic err_mismatch, err_format, err_code, err_cmd, err_oversize; // This frame's errors
	logic fr_good;
	logic [7:0] irq_event; // One-cycle event vector
	logic [7:0] irq_clear; // Write-one-to-clear bits

	// Request decode; a request already acknowledged is not taken twice
	assign bus_idx = WB_ADR_I[11:2];
	assign bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	assign bus_wr = bus_req && WB_WE_I;
	assign wr_merged = lane_merge(rd_word, WB_DAT_I, WB_SEL_I);

	// Checks on the frame summary
	always_comb begin
		fr_done = FRAME_I.valid;
		fr_clear = FRAME_I.valid && FRAME_I.tag_match;
		err_mismatch = dest_check && (FRAME_I.dest_addr != station);
		err_format = FRAME_I.access_format != GCM_ACCESS_FORMAT;
		err_code = (FRAME_I.access_code != GCM_ACCESS_CODE_A) &&
			(FRAME_I.access_code != GCM_ACCESS_CODE_B);
		err_cmd = FRAME_I.cmd_unknown;
		err_oversize = FRAME_I.byte_count > GCM_MAX_FRAME_BYTES;
		fr_good = !(err_mismatch || err_format || err_code || err_cmd || err_oversize);
	end

	// Bus answer: one wait-free cycle, ack drops the cycle after
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			WB_ACK_O <= 1'b0;
		end else begin
			WB_ACK_O <= bus_req;
		end
	end

	// Read data captured with the ack
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			WB_DAT_O <= 32'h0000_0000;
		end else if (bus_req) begin
			WB_DAT_O <= rd_word;
		end
	end

	// Read mux; unmapped words and reserved bits read zero, except drive bits 7 and 3, which read back
	always_comb begin
		rd_word = 32'h0000_0000;
		case (bus_idx)
			GCM_IDX_CTRL: begin
				rd_word[GCM_BIT_DEST_CHECK] = dest_check;
			end
			GCM_IDX_DRIVE: begin
				rd_word[7:0] = drive;
			end
			GCM_IDX_STATUS: begin
				rd_word[GCM_BIT_GOOD] = st_good;
				rd_word[GCM_BIT_RESP] = st_resp;
				rd_word[GCM_BIT_EXEC] = st_exec;
				rd_word[GCM_BIT_MISMATCH] = st_mismatch;
				rd_word[GCM_BIT_FORMAT] = st_format;
				rd_word[GCM_BIT_CODE] = st_code;
				rd_word[GCM_BIT_CMD] = st_cmd;
				rd_word[GCM_BIT_OVERSIZE] = st_oversize;
				rd_word[GCM_LOC_MSB:0] = st_loc;
			end
			GCM_IDX_OVERRIDE: begin
				rd_word[9:0] = override;
			end
			GCM_IDX_LEVEL: begin
				rd_word[9:0] = level;
			end
			GCM_IDX_STATION_LO: begin
				rd_word = station[31:0];
			end
			GCM_IDX_STATION_HI: begin
				rd_word[15:0] = station[47:32];
			end
			GCM_IDX_IRQ_STATUS: begin
				rd_word[7:0] = irq_status;
			end
			GCM_IDX_IRQ_MASK: begin
				rd_word[7:0] = irq_mask;
			end
			default: begin
				rd_word = 32'h0000_0000;
			end
		endcase
	end

	// Control register; only the destination check bit lives here
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			dest_check <= 1'b0;
		end else if (wr_hit(bus_wr, bus_idx, GCM_IDX_CTRL)) begin
			dest_check <= wr_merged[GCM_BIT_DEST_CHECK];
		end
	end

	// Drive strength; reserved bits are plain storage
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			drive <= GCM_DRIVE_RST;
		end else if (wr_hit(bus_wr, bus_idx, GCM_IDX_DRIVE) && WB_SEL_I[0]) begin
			drive <= WB_DAT_I[7:0];
		end
	end

	// Settings go straight to the pad controls
	assign HS_DRIVE_O = drive[GCM_HS_LSB +: 3];
	assign LS_DRIVE_O = drive[GCM_LS_LSB +: 3];

	// Pin override and level registers
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			override <= GCM_PIN_RST;
			level <= GCM_PIN_RST;
		end else begin
			if (wr_hit(bus_wr, bus_idx, GCM_IDX_OVERRIDE)) begin
				override <= wr_merged[9:0];
			end
			if (wr_hit(bus_wr, bus_idx, GCM_IDX_LEVEL)) begin
				level <= wr_merged[9:0];
			end
		end
	end

	// Station address, compared against each checked frame
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			station <= GCM_STATION_RST;
		end else begin
			if (wr_hit(bus_wr, bus_idx, GCM_IDX_STATION_LO)) begin
				station[31:0] <= wr_merged;
			end
			if (wr_hit(bus_wr, bus_idx, GCM_IDX_STATION_HI)) begin
				station[47:32] <= wr_merged[15:0];
			end
		end
	end

	// Good flag set by any good frame, cleared by a tag-matching frame with errors
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			st_good <= 1'b0;
		end else if (fr_done && fr_good) begin
			st_good <= 1'b1;
		end else if (fr_clear) begin
			st_good <= 1'b0;
		end
	end

	// Reply and execution flags; a set in the clearing cycle wins
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			st_resp <= 1'b0;
			st_exec <= 1'b0;
		end else begin
			if (RESP_SENT_I) begin
				st_resp <= 1'b1;
			end else if (fr_clear) begin
				st_resp <= 1'b0;
			end
			if (EXEC_DONE_I) begin
				st_exec <= 1'b1;
			end else if (fr_clear) begin
				st_exec <= 1'b0;
			end
		end
	end

	// Error flags: restart on a tag match, otherwise accumulate
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			st_mismatch <= 1'b0;
			st_format <= 1'b0;
			st_code <= 1'b0;
			st_cmd <= 1'b0;
			st_oversize <= 1'b0;
		end else if (fr_clear) begin
			// New errors of the same frame override the clear
			st_mismatch <= err_mismatch;
			st_format <= err_format;
			st_code <= err_code;
			st_cmd <= err_cmd;
			st_oversize <= err_oversize;
		end else if (fr_done) begin
			st_mismatch <= st_mismatch | err_mismatch;
			st_format <= st_format | err_format;
			st_code <= st_code | err_code;
			st_cmd <= st_cmd | err_cmd;
			st_oversize <= st_oversize | err_oversize;
		end
	end

	// Command location is only meaningful while the command flag is set
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			st_loc <= 7'h00;
		end else if (fr_done && err_cmd && !(st_cmd && !fr_clear)) begin
			st_loc <= FRAME_I.cmd_loc;
		end else if (fr_clear) begin
			st_loc <= 7'h00;
		end
	end

	// Frame verdicts toward the parser, one-cycle pulses
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			DISCARD_O <= 1'b0;
			NO_REPLY_O <= 1'b0;
		end else begin
			DISCARD_O <= fr_done && err_mismatch;
			// Oversize and discarded frames must not be answered
			NO_REPLY_O <= fr_done && (err_oversize || err_mismatch);
		end
	end

	// Event vector in interrupt bit order
	always_comb begin
		irq_event[0] = fr_done && fr_good;
		irq_event[1] = RESP_SENT_I;
		irq_event[2] = EXEC_DONE_I;
		irq_event[3] = fr_done && err_mismatch;
		irq_event[4] = fr_done && err_format;
		irq_event[5] = fr_done && err_code;
		irq_event[6] = fr_done && err_cmd;
		irq_event[7] = fr_done && err_oversize;
		irq_clear = 8'h00;
		if (wr_hit(bus_wr, bus_idx, GCM_IDX_IRQ_STATUS) && WB_SEL_I[0]) begin
			irq_clear = WB_DAT_I[7:0];
		end
	end

	// Sticky interrupt status; an event beats a clear in the same cycle
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			irq_status <= 8'h00;
		end else begin
			irq_status <= (irq_status & ~irq_clear) | irq_event;
		end
	end

	// Interrupt mask
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			irq_mask <= 8'h00;
		end else if (wr_hit(bus_wr, bus_idx, GCM_IDX_IRQ_MASK) && WB_SEL_I[0]) begin
			irq_mask <= WB_DAT_I[7:0];
		end
	end

	// Level interrupt, one cycle behind the status
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			IRQ_O <= 1'b0;
		end else begin
			IRQ_O <= |(irq_status & irq_mask);
		end
	end

	// Registered pin select, glitch-free at the pad; index 0 is first port's first pin
	for (genvar p = 0; p < GCM_PIN_COUNT; p++) begin : g_pin
		always_ff @(posedge SYS_CLK_I) begin
			if (RESET_I) begin
				INDICATOR_PIN_O[p] <= 1'b0;
			end else if (override[p]) begin
				INDICATOR_PIN_O[p] <= level[p];
			end else begin
				INDICATOR_PIN_O[p] <= INDICATOR_STATUS_I[p];
			end
		end
	end

endmodule : gcm_misc_ctrl

// *** gcm_pkg.sv ***
// Constants, register indices and carrier types of the global misc control block
package gcm_pkg;

	// Register indices; the byte address is four times the index
	localparam logic [9:0] GCM_IDX_CTRL = 10'h104;
	localparam logic [9:0] GCM_IDX_DRIVE = 10'h10D;
	localparam logic [9:0] GCM_IDX_STATUS = 10'h110;
	localparam logic [9:0] GCM_IDX_OVERRIDE = 10'h120;
	localparam logic [9:0] GCM_IDX_LEVEL = 10'h124;
	localparam logic [9:0] GCM_IDX_STATION_LO = 10'h130;
	localparam logic [9:0] GCM_IDX_STATION_HI = 10'h131;
	localparam logic [9:0] GCM_IDX_IRQ_STATUS = 10'h140;
	localparam logic [9:0] GCM_IDX_IRQ_MASK = 10'h141;

	// In-band status field positions
	localparam int GCM_BIT_GOOD = 31;
	localparam int GCM_BIT_RESP = 30;
	localparam int GCM_BIT_EXEC = 29;
	localparam int GCM_BIT_MISMATCH = 14;
	localparam int GCM_BIT_FORMAT = 13;
	localparam int GCM_BIT_CODE = 12;
	localparam int GCM_BIT_CMD = 11;
	localparam int GCM_BIT_OVERSIZE = 10;
	localparam int GCM_LOC_MSB = 6;

	// Control field position
	localparam int GCM_BIT_DEST_CHECK = 30;

	// Drive strength field positions and reset values
	localparam int GCM_HS_LSB = 4;
	localparam int GCM_LS_LSB = 0;
	localparam logic [7:0] GCM_DRIVE_RST = 8'h62;

	// Indicator pin count and reset values
	localparam int GCM_PIN_COUNT = 10;
	localparam logic [9:0] GCM_PIN_RST = 10'h000;

	// Frame check values
	localparam logic [15:0] GCM_ACCESS_FORMAT = 16'h9800;
	localparam logic [15:0] GCM_ACCESS_CODE_A = 16'h0001;
	localparam logic [15:0] GCM_ACCESS_CODE_B = 16'h0002;
	localparam logic [15:0] GCM_MAX_FRAME_BYTES = 16'h0140;

	// Station address after reset; value is arbitrary
	localparam logic [47:0] GCM_STATION_RST = 48'h0000_0000_0000;

	// Interrupt event bit count
	localparam int GCM_IRQ_COUNT = 8;

	// Summary of one received in-band management frame, valid for one cycle
	typedef struct packed {
		logic valid; // End of frame strobe
		logic tag_match; // Tag field matches
		logic [47:0] dest_addr; // Destination address
		logic [15:0] access_format; // Access format word
		logic [15:0] access_code; // Access code word
		logic cmd_unknown; // Unrecognised command code seen
		logic [6:0] cmd_loc; // Location of that command code
		logic [15:0] byte_count; // Length incl. zero pad and FCS
	} gcm_frame_s;

endpackage : gcm_pkg

// *** gcm_misc_ctrl_props.sv ***
// Property checker for the global misc control block
`timescale 1ns/1ps

module gcm_misc_ctrl_props
	import gcm_pkg::*;
(
	input wire logic SYS_CLK_I,
	input wire logic RESET_I,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [11:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	input wire logic [31:0] WB_DAT_O,
	input wire logic WB_ACK_O,
	input wire gcm_pkg::gcm_frame_s FRAME_I,
	input wire logic RESP_SENT_I,
	input wire logic EXEC_DONE_I,
	input wire logic [9:0] INDICATOR_STATUS_I,
	input wire logic [9:0] INDICATOR_PIN_O,
	input wire logic [2:0] HS_DRIVE_O,
	input wire logic [2:0] LS_DRIVE_O,
	input wire logic DISCARD_O,
	input wire logic NO_REPLY_O,
	input wire logic IRQ_O
);
	// Request on the bus and a read answer
	wire logic req = WB_CYC_I && WB_STB_I;
	wire logic rd_ack = WB_ACK_O && !WB_WE_I;
	wire logic ovr_wr = req && WB_WE_I && WB_ADR_I[11:2] == GCM_IDX_OVERRIDE;
	// Override untouched since reset, so pins must follow status
	logic ovr_set;

	// Remember any override write since reset
	always_ff @(posedge SYS_CLK_I) begin
		if (RESET_I) begin
			ovr_set <= 1'h0;
		end else if (ovr_wr) begin
			ovr_set <= 1'h1;
		end
	end

	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (RESET_I);

	ack_next_a: assert property (req && !WB_ACK_O |=> WB_ACK_O)
		else $error("ack missing one cycle after request");
	ack_once_a: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack longer than one cycle");
	status_rsvd_a: assert property (
		rd_ack && WB_ADR_I[11:2] == GCM_IDX_STATUS |-> WB_DAT_O[28:15] == 14'h0000
		&& WB_DAT_O[9:7] == 3'h0) else $error("status reserved bits not zero");
	pin_rsvd_a: assert property (
		rd_ack && (WB_ADR_I[11:2] == GCM_IDX_OVERRIDE || WB_ADR_I[11:2] == GCM_IDX_LEVEL)
		|-> WB_DAT_O[31:10] == 22'h000000) else $error("pin word reserved bits set");
	unmapped_zero_a: assert property (
		rd_ack && WB_ADR_I[11:2] == 10'h000 |-> WB_DAT_O == 32'h0000_0000)
		else $error("unmapped read not zero");
	oversize_noreply_a: assert property (
		FRAME_I.valid && FRAME_I.byte_count > GCM_MAX_FRAME_BYTES |=> NO_REPLY_O)
		else $error("oversize frame without no-reply");
	discard_cause_a: assert property (
		DISCARD_O |-> $past(FRAME_I.valid) && NO_REPLY_O)
		else $error("discard without a frame");
	drive_reset_a: assert property (
		$fell(RESET_I) |-> HS_DRIVE_O == 3'h6 && LS_DRIVE_O == 3'h2)
		else $error("drive reset values wrong");
	drive_write_a: assert property (
		$changed({HS_DRIVE_O, LS_DRIVE_O}) |->
		$past(req && WB_WE_I && WB_ADR_I[11:2] == GCM_IDX_DRIVE))
		else $error("drive changed without a write");
	pin_follow_a: assert property (
		!ovr_set && !ovr_wr |=> INDICATOR_PIN_O == $past(INDICATOR_STATUS_I))
		else $error("pin not following status");
	out_reset_a: assert property ($fell(RESET_I) |-> !IRQ_O && !DISCARD_O && !NO_REPLY_O)
		else $error("outputs active after reset");

	cover property (DISCARD_O);
	cover property (IRQ_O);
	cover property (NO_REPLY_O && !DISCARD_O);
endmodule : gcm_misc_ctrl_props

// *** global_chip_misc_control_bench.sv ***
// Self-checking bench of the global misc control block
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
	$display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end

module global_chip_misc_control_bench;
	import gcm_pkg::*;
	localparam logic [15:0] OK_F = GCM_ACCESS_FORMAT;
	localparam logic [15:0] OK_C = GCM_ACCESS_CODE_A;
	logic clk = 1'h0;
	logic rst = 1'h1;
	logic cyc = 1'h0;
	logic stb = 1'h0;
	logic we = 1'h0;
	logic [11:0] adr = 12'h000;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] rdat;
	logic ack;
	gcm_frame_s frm = '0;
	logic resp = 1'h0;
	logic exec = 1'h0;
	logic [9:0] ind = 10'h000;
	logic [9:0] pins;
	logic [2:0] hs;
	logic [2:0] ls;
	logic disc;
	logic noreply;
	logic irq;
	logic [31:0] q;
	int miscompares = 0;
	int n_tests = 0;

	gcm_misc_ctrl dut (.SYS_CLK_I(clk), .RESET_I(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
		.WB_ACK_O(ack), .FRAME_I(frm), .RESP_SENT_I(resp), .EXEC_DONE_I(exec),
		.INDICATOR_STATUS_I(ind), .INDICATOR_PIN_O(pins), .HS_DRIVE_O(hs),
		.LS_DRIVE_O(ls), .DISCARD_O(disc), .NO_REPLY_O(noreply), .IRQ_O(irq));

	// Report counts and verdict, then stop
	task automatic end_sim();
		$display("Compares %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_sim

	// One classic cycle; the bound stands in for a hung slave
	task automatic wb(input logic w, input logic [9:0] idx, input logic [31:0] d);
		int n;
		@(posedge clk);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= {idx, 2'h0};
		wdat <= d;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'h1 && n < 20);
		q = rdat;
		cyc <= 1'h0;
		stb <= 1'h0;
		if (ack !== 1'h1) begin
			miscompares++;
			end_sim();
		end
	endtask : wb

	// Read a word and compare it
	task automatic rdc(input logic [9:0] idx, input logic [31:0] e);
		wb(1'h0, idx, 32'h0000_0000);
		`CHK(q, e)
	endtask : rdc

	// One frame summary; pulses are looked at in their only cycle
	task automatic send(input logic [15:0] f, input logic [15:0] c, input logic u,
		input logic [15:0] n, input logic [47:0] ds, input logic t, input logic [31:0] st,
		input logic nr, input logic dc);
		@(posedge clk);
		frm.valid <= 1'h1;
		frm.tag_match <= t;
		frm.dest_addr <= ds;
		frm.access_format <= f;
		frm.access_code <= c;
		frm.cmd_unknown <= u;
		frm.cmd_loc <= 7'h5A;
		frm.byte_count <= n;
		@(posedge clk);
		frm.valid <= 1'h0;
		#1;
		`CHK(noreply, nr)
		`CHK(disc, dc)
		rdc(GCM_IDX_STATUS, st);
	endtask : send

	// Reset values
	task automatic t_reset();
		ind <= 10'h2A5;
		rdc(GCM_IDX_DRIVE, 32'h0000_0062);
		`CHK(hs, 3'h6)
		`CHK(ls, 3'h2)
		rdc(GCM_IDX_OVERRIDE, 32'h0000_0000);
		rdc(GCM_IDX_LEVEL, 32'h0000_0000);
		`CHK(pins, 10'h2A5)
	endtask : t_reset

	// Reset in mid-run with override, control, drive and status off their reset values
	task automatic t_rerst();
		wb(1'h1, GCM_IDX_OVERRIDE, 32'h0000_03FF);
		wb(1'h1, GCM_IDX_CTRL, 32'h4000_0000);
		rst <= 1'h1;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		rdc(GCM_IDX_DRIVE, 32'h0000_0062);
		`CHK(hs, 3'h6)
		`CHK(ls, 3'h2)
		rdc(GCM_IDX_OVERRIDE, 32'h0000_0000);
		rdc(GCM_IDX_STATUS, 32'h0000_0000);
		rdc(GCM_IDX_CTRL, 32'h0000_0000);
		`CHK(pins, 10'h3FF)
	endtask : t_rerst

	// Drive fields, read-only and reserved places
	task automatic t_drive();
		wb(1'h1, GCM_IDX_DRIVE, 32'hFFFF_FF35);
		rdc(GCM_IDX_DRIVE, 32'h0000_0035);
		`CHK(hs, 3'h3)
		`CHK(ls, 3'h5)
		wb(1'h1, GCM_IDX_STATUS, 32'hFFFF_FFFF);
		rdc(GCM_IDX_STATUS, 32'h0000_0000);
		wb(1'h1, GCM_IDX_OVERRIDE, 32'hFFFF_FC00);
		rdc(GCM_IDX_OVERRIDE, 32'h0000_0000);
		rdc(10'h000, 32'h0000_0000);
	endtask : t_drive

	// Walk each pin through output high, output low, and its neighbours' pass-through
	task automatic t_pins();
		for (int p = 0; p < GCM_PIN_COUNT; p++) begin
			wb(1'h1, GCM_IDX_OVERRIDE, 32'h1 << p);
			wb(1'h1, GCM_IDX_LEVEL, 32'h1 << p);
			ind <= 10'h000;
			repeat (2) @(posedge clk);
			#1;
			`CHK(pins, 10'h001 << p)
			wb(1'h1, GCM_IDX_LEVEL, 32'h0000_0000);
			ind <= 10'h3FF;
			repeat (2) @(posedge clk);
			#1;
			`CHK(pins, 10'h3FF ^ (10'h001 << p))
		end
		wb(1'h1, GCM_IDX_OVERRIDE, 32'h0000_0000);
	endtask : t_pins

	// Every error kind and the size boundary, tag-matching frames
	task automatic t_frames();
		send(OK_F, OK_C, 1'h0, 16'h0140, 48'h0, 1'h1, 32'h8000_0000, 1'h0, 1'h0);
		send(16'h9801, OK_C, 1'h0, 16'h0040, 48'h0, 1'h1, 32'h0000_2000, 1'h0, 1'h0);
		send(OK_F, 16'h0003, 1'h0, 16'h0040, 48'h0, 1'h1, 32'h0000_1000, 1'h0, 1'h0);
		send(OK_F, 16'h0002, 1'h0, 16'h0040, 48'h0, 1'h1, 32'h8000_0000, 1'h0, 1'h0);
		send(OK_F, OK_C, 1'h1, 16'h0040, 48'h0, 1'h1, 32'h0000_085A, 1'h0, 1'h0);
		send(OK_F, OK_C, 1'h0, 16'h0141, 48'h0, 1'h1, 32'h0000_0400, 1'h1, 1'h0);
		send(OK_F, OK_C, 1'h0, 16'h0040, 48'h1, 1'h1, 32'h8000_0000, 1'h0, 1'h0);
		wb(1'h1, GCM_IDX_CTRL, 32'h4000_0000);
		send(OK_F, OK_C, 1'h0, 16'h0040, 48'h1, 1'h1, 32'h0000_4000, 1'h1, 1'h1);
		send(OK_F, OK_C, 1'h0, 16'h0040, 48'h0, 1'h1, 32'h8000_0000, 1'h0, 1'h0);
		wb(1'h1, GCM_IDX_CTRL, 32'h0000_0000);
	endtask : t_frames

	// Reply and execution flags, kept by a foreign tag, cleared by a matching one
	task automatic t_flags();
		resp <= 1'h1;
		exec <= 1'h1;
		@(posedge clk);
		resp <= 1'h0;
		exec <= 1'h0;
		rdc(GCM_IDX_STATUS, 32'hE000_0000);
		send(16'h1234, OK_C, 1'h0, 16'h0040, 48'h0, 1'h0, 32'hE000_2000, 1'h0, 1'h0);
		send(OK_F, OK_C, 1'h0, 16'h0040, 48'h0, 1'h1, 32'h8000_0000, 1'h0, 1'h0);
	endtask : t_flags

	// Interrupt raised, cleared, then masked
	task automatic t_irq();
		wb(1'h1, GCM_IDX_IRQ_STATUS, 32'h0000_00FF);
		wb(1'h1, GCM_IDX_IRQ_MASK, 32'h0000_0010);
		send(16'h1234, OK_C, 1'h0, 16'h0040, 48'h0, 1'h1, 32'h0000_2000, 1'h0, 1'h0);
		rdc(GCM_IDX_IRQ_STATUS, 32'h0000_0010);
		`CHK(irq, 1'h1)
		wb(1'h1, GCM_IDX_IRQ_STATUS, 32'h0000_0010);
		rdc(GCM_IDX_IRQ_STATUS, 32'h0000_0000);
		`CHK(irq, 1'h0)
		wb(1'h1, GCM_IDX_IRQ_MASK, 32'h0000_0000);
		send(16'h1234, OK_C, 1'h0, 16'h0040, 48'h0, 1'h1, 32'h0000_2000, 1'h0, 1'h0);
		rdc(GCM_IDX_IRQ_STATUS, 32'h0000_0010);
		`CHK(irq, 1'h0)
	endtask : t_irq

	// Free-running clock
	initial begin
		forever #4 clk = ~clk;
	end

	// Main sequence
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'h0;
		t_reset();
		t_drive();
		t_pins();
		t_frames();
		t_flags();
		t_irq();
		t_rerst();
		end_sim();
	end
endmodule : global_chip_misc_control_bench

bind gcm_misc_ctrl gcm_misc_ctrl_props u_props (.SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I),
	.WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
	.WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
	.FRAME_I(FRAME_I), .RESP_SENT_I(RESP_SENT_I), .EXEC_DONE_I(EXEC_DONE_I),
	.INDICATOR_STATUS_I(INDICATOR_STATUS_I), .INDICATOR_PIN_O(INDICATOR_PIN_O),
	.HS_DRIVE_O(HS_DRIVE_O), .LS_DRIVE_O(LS_DRIVE_O), .DISCARD_O(DISCARD_O),
	.NO_REPLY_O(NO_REPLY_O), .IRQ_O(IRQ_O));
